// ---- design/wrs_core.sv ----
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
//
// Contract
// - 4-bit operand msb picks slice pointer a (0) or b (1)
// - chosen pointer's upper five bits form address upper five bits
// - operand's lower three bits form address lower three bits
// - 8-bit operand with upper nibble 1100B decodes as working register
// - in 8-bit working mode bit 3 picks pointer, pointer gives upper five
// - pointer decremented before each push, incremented after each pop
// - call pushes program counter, return pops it back
// - interrupt pushes program counter and flags, interrupt return pops both
// - stack pointer high byte at D8H, low byte at D9H
// - stack pointer is not initialised by reset; here reset clears it to zero
// - low byte wrap carries or borrows into the high byte
// - indirect addresses C0H-FFH steer to the other register set
// - indirect mode takes any register or even pair as pointer
// - plain register mode uses the named register contents as operand
// - after reset slice pointers hold C0H and C8H
// - slice pointers are registers at D6H and D7H
// - register pairs start even, msb in even, lsb in odd
module wrs_core
  import wrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // operand address generation
  input wire logic [3:0] op4,
  output logic [7:0] op4_addr,
  input wire logic [7:0] op8,
  output logic [7:0] op8_addr,
  output logic op8_working,
  input wire logic [7:0] ind_ptr,
  input wire logic ind_pair,
  output logic [7:0] ind_addr,
  output logic ind_set2,
  output logic [7:0] pair_hi_addr,
  output logic [7:0] pair_lo_addr,
  // stack sequencer
  input wire logic [2:0] stk_cmd,
  input wire logic [7:0] stk_wbyte,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] mem_rdata,
  output logic stk_busy,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out,
  output logic [7:0] pop_byte,
  output logic stk_done
);
  typedef struct packed {
    logic [7:0] ptr_a;
    logic [7:0] ptr_b;
    logic [15:0] sp;
    wrs_state_t st;
    wrs_cmd_t cmd;
    logic [2:0] left;
    logic [7:0] rdata;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_wr;
    logic mem_rd;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0] pop_byte;
    logic done;
  } wrs_state_s_t;

  wrs_state_s_t s_r;
  wrs_state_s_t s_nxt;
  wrs_sp_if spi ();

  // shared working-register decode of a 4-bit field
  function automatic logic [7:0] wrs_work_addr(input logic [3:0] f,
                                                input logic [7:0] pa,
                                                input logic [7:0] pb);
    logic [7:0] p;
    p = f[WRS_SEL_BIT] ? pb : pa;
    return {p[7:3], f[2:0]};
  endfunction

  // address generation from live pointers, no extra latency
  always_comb begin
    op4_addr = wrs_work_addr(op4, s_r.ptr_a, s_r.ptr_b);
    op8_working = (op8[7:4] == WRS_WORK8_TAG);
    op8_addr = op8_working ? wrs_work_addr(op8[3:0], s_r.ptr_a, s_r.ptr_b) : op8;
    ind_addr = ind_pair ? {ind_ptr[7:1], 1'b0} : ind_ptr;
    ind_set2 = (ind_ptr[7:6] == WRS_UPPER_SET1_TAG);
    pair_hi_addr = {op8_addr[7:1], 1'b0};
    pair_lo_addr = {op8_addr[7:1], 1'b1};
  end

  wrs_sp_step u_step (
    .port_s(spi.alu)
  );

  // stack step requests: decrement before a push, increment after a pop
  assign spi.sp = s_r.sp;
  assign spi.dec = (s_r.st == WRS_ST_PUSH);
  assign spi.inc = (s_r.st == WRS_ST_POP);

  always_comb begin
    s_nxt = s_r;
    s_nxt.mem_wr = 1'b0;
    s_nxt.mem_rd = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.rdata = 8'h00;
    // register reads; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        WRS_SLICE_PTR_A_OFS: s_nxt.rdata = s_r.ptr_a;
        WRS_SLICE_PTR_B_OFS: s_nxt.rdata = s_r.ptr_b;
        WRS_STACK_PTR_HI_OFS: s_nxt.rdata = s_r.sp[15:8];
        WRS_STACK_PTR_LO_OFS: s_nxt.rdata = s_r.sp[7:0];
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    case (s_r.st)
      WRS_ST_IDLE: begin
        // a new command is taken only while idle
        case (wrs_cmd_t'(stk_cmd))
          WRS_CMD_PUSH: begin
            s_nxt.cmd = WRS_CMD_PUSH;
            s_nxt.left = 3'h1;
            s_nxt.st = WRS_ST_PUSH;
          end
          WRS_CMD_CALL: begin
            s_nxt.cmd = WRS_CMD_CALL;
            s_nxt.left = WRS_CALL_BYTES;
            s_nxt.st = WRS_ST_PUSH;
          end
          WRS_CMD_INT: begin
            s_nxt.cmd = WRS_CMD_INT;
            s_nxt.left = WRS_INT_BYTES;
            s_nxt.st = WRS_ST_PUSH;
          end
          WRS_CMD_POP: begin
            s_nxt.cmd = WRS_CMD_POP;
            s_nxt.left = 3'h1;
            s_nxt.st = WRS_ST_POP;
          end
          WRS_CMD_RET: begin
            s_nxt.cmd = WRS_CMD_RET;
            s_nxt.left = WRS_CALL_BYTES;
            s_nxt.st = WRS_ST_POP;
          end
          WRS_CMD_INTERRUPT_RETURN: begin
            s_nxt.cmd = WRS_CMD_INTERRUPT_RETURN;
            s_nxt.left = WRS_INT_BYTES;
            s_nxt.st = WRS_ST_POP;
          end
          default: s_nxt.st = WRS_ST_IDLE;
        endcase
        if (wrs_cmd_t'(stk_cmd) != WRS_CMD_NONE) begin
          s_nxt.pc = pc_in;
          s_nxt.flags = flags_in;
        end
      end
      WRS_ST_PUSH: begin
        // write at the already-decremented address; order pc lo, pc hi, flags
        s_nxt.sp = spi.sp_nxt;
        s_nxt.mem_addr = spi.sp_nxt[7:0];
        s_nxt.mem_wr = 1'b1;
        case (s_r.left)
          3'h3: s_nxt.mem_wdata = s_r.pc[7:0];
          3'h2: s_nxt.mem_wdata = (s_r.cmd == WRS_CMD_INT) ? s_r.pc[15:8] : s_r.pc[7:0];
          3'h1: begin
            case (s_r.cmd)
              WRS_CMD_INT: s_nxt.mem_wdata = s_r.flags;
              WRS_CMD_CALL: s_nxt.mem_wdata = s_r.pc[15:8];
              default: s_nxt.mem_wdata = stk_wbyte;
            endcase
          end
          default: s_nxt.mem_wdata = 8'h00;
        endcase
        s_nxt.left = s_r.left - 3'h1;
        s_nxt.st = (s_r.left == 3'h1) ? WRS_ST_DONE : WRS_ST_PUSH;
      end
      WRS_ST_POP: begin
        // read the top, then step up; data lands next cycle
        s_nxt.mem_addr = s_r.sp[7:0];
        s_nxt.mem_rd = 1'b1;
        s_nxt.sp = spi.sp_nxt;
        s_nxt.st = WRS_ST_DONE;
      end
      WRS_ST_DONE: begin
        // collect previous pop byte; pop order mirrors push order
        if (s_r.mem_rd) begin
          case (s_r.cmd)
            WRS_CMD_INTERRUPT_RETURN: begin
              case (s_r.left)
                3'h3: s_nxt.flags = mem_rdata;
                3'h2: s_nxt.pc[15:8] = mem_rdata;
                default: s_nxt.pc[7:0] = mem_rdata;
              endcase
            end
            WRS_CMD_RET: begin
              if (s_r.left == 3'h2) begin
                s_nxt.pc[15:8] = mem_rdata;
              end else begin
                s_nxt.pc[7:0] = mem_rdata;
              end
            end
            default: s_nxt.pop_byte = mem_rdata;
          endcase
          s_nxt.left = s_r.left - 3'h1;
          s_nxt.st = (s_r.left == 3'h1) ? WRS_ST_IDLE : WRS_ST_POP;
          s_nxt.done = (s_r.left == 3'h1);
        end else begin
          s_nxt.st = WRS_ST_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = WRS_ST_IDLE;
    endcase
    // software writes win over the sequencer in every state, busy or idle
    if (reg_wr) begin
      case (reg_addr)
        WRS_SLICE_PTR_A_OFS: s_nxt.ptr_a = reg_wdata;
        WRS_SLICE_PTR_B_OFS: s_nxt.ptr_b = reg_wdata;
        WRS_STACK_PTR_HI_OFS: s_nxt.sp[15:8] = reg_wdata;
        WRS_STACK_PTR_LO_OFS: s_nxt.sp[7:0] = reg_wdata;
        default: s_nxt.ptr_a = s_nxt.ptr_a;
      endcase
    end
  end

  // sp has no meaningful reset value; it is cleared only to keep x out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ptr_a <= WRS_SLICE_PTR_A_RST;
      s_r.ptr_b <= WRS_SLICE_PTR_B_RST;
      s_r.st <= WRS_ST_IDLE;
      s_r.cmd <= WRS_CMD_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign stk_busy = (s_r.st != WRS_ST_IDLE);
  assign mem_addr = s_r.mem_addr;
  assign mem_wdata = s_r.mem_wdata;
  assign mem_wr = s_r.mem_wr;
  assign mem_rd = s_r.mem_rd;
  assign pc_out = s_r.pc;
  assign flags_out = s_r.flags;
  assign pop_byte = s_r.pop_byte;
  assign stk_done = s_r.done;

  // operand address checks
  chk_work4_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    op4_addr == {(op4[3] ? s_r.ptr_b[7:3] : s_r.ptr_a[7:3]), op4[2:0]})
    else $error("working 4-bit address wrong");
  chk_work8_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (op8[7:4] == 4'hC) |-> op8_addr == op4_addr || op4 != op8[3:0])
    else $error("working 8-bit address wrong");
  chk_plain_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    (op8[7:4] != 4'hC) |-> op8_addr == op8)
    else $error("plain register address changed");
  chk_ind_steer: assert property (@(posedge core_clk) disable iff (!rst_n)
    ind_set2 == (ind_ptr >= 8'hC0))
    else $error("indirect steer wrong");
  chk_ind_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    ind_addr == (ind_pair ? {ind_ptr[7:1], 1'b0} : ind_ptr))
    else $error("indirect pointer address wrong");
  chk_pair_even: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pair_hi_addr[0] && pair_lo_addr == {pair_hi_addr[7:1], 1'b1})
    else $error("register pair not even then odd");
  chk_work_live: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($changed(s_r.ptr_a) && !op4[3]) |-> op4_addr[7:3] == s_r.ptr_a[7:3])
    else $error("working address lags pointer");
  // register port checks; a read answers in the following cycle
  chk_ptr_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> s_r.ptr_a == WRS_SLICE_PTR_A_RST && s_r.ptr_b == WRS_SLICE_PTR_B_RST)
    else $error("slice pointers not at reset values");
  chk_reg_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'hD6 && !$past(reg_wr)) |=> reg_rdata == $past(s_r.ptr_a))
    else $error("slice pointer read wrong");
  chk_ptr_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == WRS_SLICE_PTR_A_OFS) |=> s_r.ptr_a == $past(reg_wdata))
    else $error("slice pointer write lost");
  chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && (reg_addr < 8'hD6 || reg_addr > 8'hD9)) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_sp_read_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == WRS_STACK_PTR_HI_OFS) |=> reg_rdata == $past(s_r.sp[15:8]))
    else $error("stack pointer high read wrong");
  chk_sp_read_lo: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == WRS_STACK_PTR_LO_OFS) |=> reg_rdata == $past(s_r.sp[7:0]))
    else $error("stack pointer low read wrong");
  // stack checks; a software write to the pointer mid-frame would upset the counts
  chk_push_pre_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_wr |-> {8'h00, mem_addr} == {8'h00, s_r.sp[7:0]})
    else $error("push not at decremented pointer");
  chk_pop_top: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_rd |-> mem_addr == $past(s_r.sp[7:0]))
    else $error("pop not at top of stack");
  chk_pop_post_inc: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_rd |-> s_r.sp == $past(s_r.sp) + 16'h0001)
    else $error("pop did not step pointer");
  chk_push_borrow: assert property (@(posedge core_clk) disable iff (!rst_n)
    (spi.dec && s_r.sp[7:0] == 8'h00 && !reg_wr) |=>
    s_r.sp[15:8] == $past(s_r.sp[15:8]) - 8'h01)
    else $error("push did not borrow from high byte");
  chk_pop_carry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (spi.inc && s_r.sp[7:0] == 8'hFF && !reg_wr) |=>
    s_r.sp[15:8] == $past(s_r.sp[15:8]) + 8'h01)
    else $error("pop did not carry into high byte");
  chk_call_two: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == WRS_ST_IDLE && stk_cmd == 3'h3 && !reg_wr) |=>
    ##2 s_r.sp == $past(s_r.sp, 3) - 16'h0002)
    else $error("call frame not two bytes");
  chk_ret_two: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == WRS_ST_IDLE && stk_cmd == 3'h4 && !reg_wr) |=>
    ##3 s_r.sp == $past(s_r.sp, 4) + 16'h0002)
    else $error("return frame not two bytes");
  chk_int_three: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == WRS_ST_IDLE && stk_cmd == 3'h5 && !reg_wr) |=>
    ##3 s_r.sp == $past(s_r.sp, 4) - 16'h0003)
    else $error("interrupt frame not three bytes");
  chk_interrupt_return_three: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == WRS_ST_IDLE && stk_cmd == 3'h6 && !reg_wr) |=>
    ##5 s_r.sp == $past(s_r.sp, 6) + 16'h0003)
    else $error("interrupt return frame not three bytes");
  chk_done_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    stk_done |-> !stk_busy)
    else $error("done pulse while busy");
  // main scenarios
  cov_call: cover property (@(posedge core_clk) disable iff (!rst_n)
    stk_cmd == 3'h3 ##[1:8] stk_done);
  cov_interrupt_return: cover property (@(posedge core_clk) disable iff (!rst_n)
    stk_cmd == 3'h6 ##[1:12] stk_done);
  cov_work8: cover property (@(posedge core_clk) disable iff (!rst_n) op8_working && op8[3]);
  cov_push_borrow: cover property (@(posedge core_clk) disable iff (!rst_n)
    spi.dec && s_r.sp[7:0] == 8'h00);
  cov_ind_steer: cover property (@(posedge core_clk) disable iff (!rst_n) ind_set2);
endmodule

// ---- design/wrs_pkg.sv ----
package wrs_pkg;
  // register map of this block
  localparam logic [7:0] WRS_SLICE_PTR_A_OFS = 8'hD6;
  localparam logic [7:0] WRS_SLICE_PTR_B_OFS = 8'hD7;
  localparam logic [7:0] WRS_STACK_PTR_HI_OFS = 8'hD8;
  localparam logic [7:0] WRS_STACK_PTR_LO_OFS = 8'hD9;
  // reset values: slice pointers aim at the common area
  localparam logic [7:0] WRS_SLICE_PTR_A_RST = 8'hC0;
  localparam logic [7:0] WRS_SLICE_PTR_B_RST = 8'hC8;
  // operand decode fields
  localparam logic [3:0] WRS_WORK8_TAG = 4'hC;
  localparam int WRS_SEL_BIT = 3;
  // upper quarter of set 1 (C0H-FFH), steered to set 2 on indirect access
  localparam logic [1:0] WRS_UPPER_SET1_TAG = 2'h3;
  // stack frame sizes in bytes
  localparam logic [2:0] WRS_CALL_BYTES = 3'h2;
  localparam logic [2:0] WRS_INT_BYTES = 3'h3;
  // stack sequencer commands
  typedef enum logic [2:0] {
    WRS_CMD_NONE = 3'h0,
    WRS_CMD_PUSH = 3'h1,
    WRS_CMD_POP = 3'h2,
    WRS_CMD_CALL = 3'h3,
    WRS_CMD_RET = 3'h4,
    WRS_CMD_INT = 3'h5,
    WRS_CMD_INTERRUPT_RETURN = 3'h6
  } wrs_cmd_t;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    WRS_ST_IDLE = 4'h1,
    WRS_ST_PUSH = 4'h2,
    WRS_ST_POP = 4'h4,
    WRS_ST_DONE = 4'h8
  } wrs_state_t;
endpackage

// ---- design/wrs_sp_if.sv ----
`timescale 1ns/100ps
// stack pointer arithmetic request and answer
interface wrs_sp_if;
  logic [15:0] sp;
  logic dec;
  logic inc;
  logic [15:0] sp_nxt;
  modport core (output sp, output dec, output inc, input sp_nxt);
  modport alu (input sp, input dec, input inc, output sp_nxt);
endinterface

// ---- design/wrs_sp_step.sv ----
`timescale 1ns/100ps
// sixteen-bit step so low-byte wrap carries into the high byte
module wrs_sp_step
  import wrs_pkg::*;
(
  wrs_sp_if.alu port_s
);
  always_comb begin
    if (port_s.dec) begin
      port_s.sp_nxt = port_s.sp - 16'h0001;
    end else if (port_s.inc) begin
      port_s.sp_nxt = port_s.sp + 16'h0001;
    end else begin
      port_s.sp_nxt = port_s.sp;
    end
  end
endmodule

// ---- sim/test_working_reg_addr_and_stack.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module test_working_reg_addr_and_stack
  import wrs_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ind_pair = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, op8 = 8'h00, op4_addr;
  logic [7:0] op8_addr, ind_ptr = 8'h00, ind_addr, pair_hi_addr, pair_lo_addr;
  logic [7:0] stk_wbyte = 8'h00, flags_in = 8'h00, mem_rdata, mem_addr, mem_wdata;
  logic [7:0] flags_out, pop_byte;
  logic [3:0] op4 = 4'h0;
  logic [2:0] stk_cmd = 3'h0;
  logic [15:0] pc_in = 16'h0000, pc_out;
  logic op8_working, ind_set2, stk_busy, mem_wr, mem_rd, stk_done;
  int num_errors = 0, check_count = 0;

  wrs_core DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op4(op4), .op4_addr(op4_addr), .op8(op8), .op8_addr(op8_addr),
    .op8_working(op8_working), .ind_ptr(ind_ptr), .ind_pair(ind_pair),
    .ind_addr(ind_addr), .ind_set2(ind_set2), .pair_hi_addr(pair_hi_addr),
    .pair_lo_addr(pair_lo_addr), .stk_cmd(stk_cmd), .stk_wbyte(stk_wbyte),
    .pc_in(pc_in), .flags_in(flags_in), .mem_rdata(mem_rdata), .stk_busy(stk_busy),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .pc_out(pc_out), .flags_out(flags_out), .pop_byte(pop_byte), .stk_done(stk_done));
  wrs_stack_mem MEM (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask

  // data sampled in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic sp_is(input logic [15:0] e);
    logic [7:0] h, l;
    rd(WRS_STACK_PTR_HI_OFS, h);
    rd(WRS_STACK_PTR_LO_OFS, l);
    `CHK("stack_pointer", e, {h, l})
  endtask

  // command held for one accepting edge, then a bounded wait for done
  task automatic stk(input wrs_cmd_t c);
    int n;
    @(posedge core_clk) stk_cmd <= c;
    @(posedge core_clk) stk_cmd <= WRS_CMD_NONE;
    #1;
    `CHK("stk_busy", 1'b1, stk_busy)
    for (n = 0; n < 40 && stk_done !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (stk_done !== 1'b1) begin
      num_errors++;
      $display("ERROR stk_done exp 1 got 0");
      stop_test();
    end
    `CHK("stk_busy", 1'b0, stk_busy)
  endtask

  task automatic t_reset();
    logic [7:0] d;
    rd(WRS_SLICE_PTR_A_OFS, d);
    `CHK("slice_pointer_a", WRS_SLICE_PTR_A_RST, d)
    rd(WRS_SLICE_PTR_B_OFS, d);
    `CHK("slice_pointer_b", WRS_SLICE_PTR_B_RST, d)
    wr(8'h10, 8'h5A);
    rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    $display("test reset done");
  endtask

  task automatic t_work();
    logic [7:0] d, p;
    wr(WRS_SLICE_PTR_A_OFS, 8'h70);
    wr(WRS_SLICE_PTR_B_OFS, 8'hAD);
    rd(WRS_SLICE_PTR_B_OFS, d);
    `CHK("slice_pointer_b", 8'hAD, d)
    // odd low bits in pointer b must not leak into the address
    for (int i = 0; i < 16; i++) begin
      p = i[3] ? 8'hAD : 8'h70;
      @(posedge core_clk) begin op4 <= i[3:0]; op8 <= {4'hC, i[3:0]}; end
      #1;
      `CHK("op4_addr", {p[7:3], i[2:0]}, op4_addr)
      `CHK("op8_addr", {p[7:3], i[2:0]}, op8_addr)
      `CHK("op8_working", 1'b1, op8_working)
    end
    @(posedge core_clk) op8 <= 8'h35;
    #1;
    `CHK("op8_addr", 8'h35, op8_addr)
    `CHK("op8_working", 1'b0, op8_working)
    `CHK("pair_hi_addr", 8'h34, pair_hi_addr)
    `CHK("pair_lo_addr", 8'h35, pair_lo_addr)
    $display("test working done");
  endtask

  task automatic t_ind();
    logic [7:0] ptr [4] = '{8'hBF, 8'hC0, 8'hFF, 8'h47};
    logic exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) begin ind_ptr <= ptr[i]; ind_pair <= 1'b0; end
      #1;
      `CHK("ind_set2", exp[i], ind_set2)
      `CHK("ind_addr", ptr[i], ind_addr)
    end
    @(posedge core_clk) ind_pair <= 1'b1;
    #1;
    `CHK("ind_addr pair", 8'h46, ind_addr)
    $display("test indirect done");
  endtask

  task automatic t_stack();
    // low byte at 00 so the push must borrow from the high byte
    wr(WRS_STACK_PTR_HI_OFS, 8'h12);
    wr(WRS_STACK_PTR_LO_OFS, 8'h00);
    @(posedge core_clk) stk_wbyte <= 8'hAB;
    stk(WRS_CMD_PUSH);
    `CHK("pushed byte", 8'hAB, MEM.ram[8'hFF])
    sp_is(16'h11FF);
    stk(WRS_CMD_POP);
    `CHK("pop_byte", 8'hAB, pop_byte)
    sp_is(16'h1200);
    $display("test stack done");
  endtask

  task automatic t_frames();
    wr(WRS_STACK_PTR_HI_OFS, 8'h00);
    wr(WRS_STACK_PTR_LO_OFS, 8'hFF);
    @(posedge core_clk) begin pc_in <= 16'h1234; flags_in <= 8'h5A; end
    stk(WRS_CMD_CALL);
    `CHK("call frame", 16'h1234, {MEM.ram[8'hFD], MEM.ram[8'hFE]})
    sp_is(16'h00FD);
    // pc input cleared so the returned value can only come from the stack
    @(posedge core_clk) pc_in <= 16'h0000;
    stk(WRS_CMD_RET);
    `CHK("pc_out", 16'h1234, pc_out)
    sp_is(16'h00FF);
    @(posedge core_clk) pc_in <= 16'h5678;
    stk(WRS_CMD_INT);
    sp_is(16'h00FC);
    @(posedge core_clk) begin pc_in <= 16'h0000; flags_in <= 8'h00; end
    stk(WRS_CMD_INTERRUPT_RETURN);
    `CHK("pc_out", 16'h5678, pc_out)
    `CHK("flags_out", 8'h5A, flags_out)
    sp_is(16'h00FF);
    $display("test frames done");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_work();
    t_ind();
    t_stack();
    t_frames();
    stop_test();
  end
endmodule

// ---- sim/wrs_stack_mem.sv ----
`timescale 1ns/100ps
// stack memory seen by the sequencer; read data stand while mem_rd is high
module wrs_stack_mem (
  input wire logic core_clk,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:255];
  logic [7:0] junk_r = 8'h00;
  // writes land on the edge; junk turns over so a stray sample shows up
  always @(posedge core_clk) begin
    if (mem_wr) ram[mem_addr] <= mem_wdata;
    junk_r <= ~junk_r;
  end
  // the sequencer takes the byte at the edge that closes its read cycle
  assign mem_rdata = mem_rd ? ram[mem_addr] : junk_r;
endmodule
